// ===== pkg/spc_pkg.sv
// Shared constants and types for the scan port connect control block.
// Notes on behaviour
// - In primary Pause-IR, accept and answer select protocols; sync code is recognised.
// - In primary Update-IR, ignore select protocols entirely.
// - Connect status comes from the last valid address versus straps and three global codes.
// - A strap match first sends an acknowledge on the primary port.
// - After the acknowledge completes, go ON: data paths and mode select connected.
// - Non-matching ordinary address: OFF at once, outputs off, mode select held, no ack.
// - Disconnect code 3FE: OFF at once like a mismatch, no acknowledge.
// - All-zero code: RESET at once, outputs off, secondary mode select high, no ack.
// - Sync code 3FF with both ports paused: MULTICAST, primary out off, no ack.
// - Sync code with either port in reset or idle counts as disconnect.
// - Bypass pin low forces bypass, connect indicator low, reception disabled.
// - Bypass joins data paths asynchronously; mode select passes unless test reset is low.
// - Bypass holds the protocol receiver in its power-up state.
// - Bypass release restores the last protocol status and re-enables reception.
// - Test reset always passes through; when low with bypass high, TRST status.
// - Test reset with bypass low gives combined status; mode select high, no reception.
// - Bypass high: indicator low only after MATCH or sync; high during acknowledge.
// - Primary port state tracked by a standard state machine on the test clock.
// - Protocols only in reset, idle and the pause states; sync code only when paused.
// - An address shorter than ten bits is a hard error and gives OFF.
// - Primary monitor powers up in Test-Logic-Reset and is forced there by test reset.
`default_nettype none

package spc_pkg;

  localparam int unsigned ADDR_W = 10;

  localparam logic [ADDR_W-1:0] RESET_CODE      = 10'h000;
  localparam logic [ADDR_W-1:0] GLOBAL_DISC_CODE = 10'h3FE;
  localparam logic [ADDR_W-1:0] GLOBAL_SYNC_CODE = 10'h3FF;

  typedef enum logic [15:0] {
    TAP_RESET  = 16'h0001,
    TAP_IDLE   = 16'h0002,
    TAP_SELDR  = 16'h0004,
    TAP_CAPDR  = 16'h0008,
    TAP_SHDR   = 16'h0010,
    TAP_EX1DR  = 16'h0020,
    TAP_PAUSDR = 16'h0040,
    TAP_EX2DR  = 16'h0080,
    TAP_UPDDR  = 16'h0100,
    TAP_SELIR  = 16'h0200,
    TAP_CAPIR  = 16'h0400,
    TAP_SHIR   = 16'h0800,
    TAP_EX1IR  = 16'h1000,
    TAP_PAUSIR = 16'h2000,
    TAP_EX2IR  = 16'h4000,
    TAP_UPDIR  = 16'h8000
  } spc_tap_t;

  typedef enum logic [4:0] {
    CONN_OFF   = 5'h01,
    CONN_ACK   = 5'h02,
    CONN_ON    = 5'h04,
    CONN_RESET = 5'h08,
    CONN_MCAST = 5'h10
  } spc_conn_t;

endpackage : spc_pkg

`default_nettype wire

// ===== logic/spc_tap_monitor.sv
// Standard test-port state follower, one per observed port.
`default_nettype none

module spc_tap_monitor (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             tms_i,
  output var spc_pkg::spc_tap_t state_o
);

  spc_pkg::spc_tap_t state_d;
  spc_pkg::spc_tap_t state_q;

  always_comb begin
    case (state_q)
      spc_pkg::TAP_RESET:  state_d = tms_i ? spc_pkg::TAP_RESET  : spc_pkg::TAP_IDLE;
      spc_pkg::TAP_IDLE:   state_d = tms_i ? spc_pkg::TAP_SELDR  : spc_pkg::TAP_IDLE;
      spc_pkg::TAP_SELDR:  state_d = tms_i ? spc_pkg::TAP_SELIR  : spc_pkg::TAP_CAPDR;
      spc_pkg::TAP_CAPDR:  state_d = tms_i ? spc_pkg::TAP_EX1DR  : spc_pkg::TAP_SHDR;
      spc_pkg::TAP_SHDR:   state_d = tms_i ? spc_pkg::TAP_EX1DR  : spc_pkg::TAP_SHDR;
      spc_pkg::TAP_EX1DR:  state_d = tms_i ? spc_pkg::TAP_UPDDR  : spc_pkg::TAP_PAUSDR;
      spc_pkg::TAP_PAUSDR: state_d = tms_i ? spc_pkg::TAP_EX2DR  : spc_pkg::TAP_PAUSDR;
      spc_pkg::TAP_EX2DR:  state_d = tms_i ? spc_pkg::TAP_UPDDR  : spc_pkg::TAP_SHDR;
      spc_pkg::TAP_UPDDR:  state_d = tms_i ? spc_pkg::TAP_SELDR  : spc_pkg::TAP_IDLE;
      spc_pkg::TAP_SELIR:  state_d = tms_i ? spc_pkg::TAP_RESET  : spc_pkg::TAP_CAPIR;
      spc_pkg::TAP_CAPIR:  state_d = tms_i ? spc_pkg::TAP_EX1IR  : spc_pkg::TAP_SHIR;
      spc_pkg::TAP_SHIR:   state_d = tms_i ? spc_pkg::TAP_EX1IR  : spc_pkg::TAP_SHIR;
      spc_pkg::TAP_EX1IR:  state_d = tms_i ? spc_pkg::TAP_UPDIR  : spc_pkg::TAP_PAUSIR;
      spc_pkg::TAP_PAUSIR: state_d = tms_i ? spc_pkg::TAP_EX2IR  : spc_pkg::TAP_PAUSIR;
      spc_pkg::TAP_EX2IR:  state_d = tms_i ? spc_pkg::TAP_UPDIR  : spc_pkg::TAP_SHIR;
      spc_pkg::TAP_UPDIR:  state_d = tms_i ? spc_pkg::TAP_SELDR  : spc_pkg::TAP_IDLE;
      default:             state_d = spc_pkg::TAP_RESET;
    endcase
  end

  // Advances on the mode-select level at each rising test-clock edge.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= spc_pkg::TAP_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign state_o = state_q;

endmodule // spc_tap_monitor

`default_nettype wire

// ===== logic/spc_connect_ctrl.sv
// Connect-status control between a multidrop primary test port and a secondary port.
`default_nettype none

module spc_connect_ctrl #(
  parameter int unsigned ADDR_W = spc_pkg::ADDR_W
) (
  // System clock domain.
  input  wire logic              mclk_i,
  input  wire logic              rst_b_i,
  // Primary test port; its clock is the link clock.
  input  wire logic              primary_test_clock_i,
  input  wire logic              primary_test_reset_n_i,
  input  wire logic              primary_mode_select_i,
  input  wire logic              primary_serial_in_i,
  output logic                   primary_serial_out_o,
  output logic                   primary_serial_out_oe_o,
  // Secondary test port.
  output logic                   secondary_test_clock_o,
  output logic                   secondary_test_reset_n_o,
  output logic                   secondary_mode_select_o,
  output logic                   secondary_serial_out_o,
  output logic                   secondary_serial_out_oe_o,
  input  wire logic              secondary_serial_in_i,
  // Straps and bypass pin.
  input  wire logic [ADDR_W-1:0] strap_address_i,
  input  wire logic              protocol_bypass_n_i,
  output logic                   connect_indicator_n_o,
  // Protocol receiver and acknowledge sender, both on the link clock.
  input  wire logic [ADDR_W-1:0] rx_addr_i,
  input  wire logic              rx_addr_valid_i,
  input  wire logic              rx_addr_short_i,
  input  wire logic              ack_done_i,
  output logic                   ack_start_o,
  output logic                   rx_enable_o,
  output logic                   rx_sync_enable_o,
  output logic                   rx_hold_o,
  // Status mirrored into the system domain.
  output logic                   connected_o,
  output logic                   ack_busy_o
);

  // ---------------- System-domain reset release ----------------

  logic rst_sync1_q;
  logic rst_sync2_q;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end

  // ---------------- Link-domain reset ----------------

  // Either the system reset or the test reset pin clears the link logic at once;
  // release is retimed to the test clock so no flop leaves reset on a partial edge.
  logic link_arst_n;
  logic lrst1_q;
  logic lrst2_q;

  assign link_arst_n = rst_b_i & primary_test_reset_n_i;

  always_ff @(posedge primary_test_clock_i or negedge link_arst_n) begin
    if (!link_arst_n) begin
      lrst1_q <= 1'b0;
      lrst2_q <= 1'b0;
    end else begin
      lrst1_q <= 1'b1;
      lrst2_q <= lrst1_q;
    end
  end

  // ---------------- Pin synchronisers into the link domain ----------------

  logic [ADDR_W-1:0] strap1_q;
  logic [ADDR_W-1:0] strap2_q;
  logic              byp1_q;
  logic              byp2_q;

  // No reset here: clearing these would match strobes against a zero strap, or block
  // strobes with bypass already high, for two edges after every test reset.
  always_ff @(posedge primary_test_clock_i) begin
    strap1_q <= strap_address_i;
    strap2_q <= strap1_q;
  end

  always_ff @(posedge primary_test_clock_i) begin
    byp1_q <= protocol_bypass_n_i;
    byp2_q <= byp1_q;
  end

  // ---------------- Port state monitors ----------------

  spc_pkg::spc_tap_t prim_state;
  spc_pkg::spc_tap_t sec_state;

  spc_tap_monitor u_prim_mon (
    .clk_i   (primary_test_clock_i),
    .rst_n_i (lrst2_q),
    .tms_i   (primary_mode_select_i),
    .state_o (prim_state)
  );

  // The secondary clock is the primary clock buffered, so its follower shares the domain.
  spc_tap_monitor u_sec_mon (
    .clk_i   (primary_test_clock_i),
    .rst_n_i (lrst2_q),
    .tms_i   (secondary_mode_select_o),
    .state_o (sec_state)
  );

  // ---------------- Acceptance windows ----------------

  logic prim_paused;
  logic sec_paused;
  logic accept_state;
  logic accept;

  assign prim_paused = (prim_state == spc_pkg::TAP_PAUSDR) ||
                       (prim_state == spc_pkg::TAP_PAUSIR);
  assign sec_paused  = (sec_state == spc_pkg::TAP_PAUSDR) ||
                       (sec_state == spc_pkg::TAP_PAUSIR);

  // Update-IR and every other transient state fall outside this set.
  assign accept_state = (prim_state == spc_pkg::TAP_RESET) ||
                        (prim_state == spc_pkg::TAP_IDLE) ||
                        prim_paused;

  // Bypass (synchronised) and test reset (held by the link reset) both block updates.
  assign accept = rx_addr_valid_i && accept_state && byp2_q;

  // ---------------- Address decode ----------------

  spc_pkg::spc_conn_t result;

  always_comb begin
    if (rx_addr_short_i) begin
      result = spc_pkg::CONN_OFF;
    end else if (rx_addr_i == spc_pkg::RESET_CODE) begin
      result = spc_pkg::CONN_RESET;
    end else if (rx_addr_i == spc_pkg::GLOBAL_SYNC_CODE) begin
      if (prim_paused && sec_paused) begin
        result = spc_pkg::CONN_MCAST;
      end else begin
        result = spc_pkg::CONN_OFF;
      end
    end else if (rx_addr_i == spc_pkg::GLOBAL_DISC_CODE) begin
      result = spc_pkg::CONN_OFF;
    end else if (rx_addr_i == strap2_q) begin
      result = spc_pkg::CONN_ACK;
    end else begin
      result = spc_pkg::CONN_OFF;
    end
  end

  // ---------------- Connect status ----------------

  spc_pkg::spc_conn_t conn_q;

  // The status survives bypass untouched, which is what lets release restore it.
  always_ff @(posedge primary_test_clock_i or negedge lrst2_q) begin
    if (!lrst2_q) begin
      conn_q <= spc_pkg::CONN_OFF;
    end else if (accept) begin
      conn_q <= result;
    end else if (conn_q == spc_pkg::CONN_ACK && ack_done_i) begin
      conn_q <= spc_pkg::CONN_ON;
    end
  end

  always_ff @(posedge primary_test_clock_i or negedge lrst2_q) begin
    if (!lrst2_q) begin
      ack_start_o <= 1'b0;
    end else begin
      ack_start_o <= accept && (result == spc_pkg::CONN_ACK);
    end
  end

  // ---------------- Routing ----------------

  logic byp_act;
  logic trst_act;
  logic on_st;
  logic mcast_st;
  logic hold_q;

  assign byp_act  = ~protocol_bypass_n_i;
  assign trst_act = ~primary_test_reset_n_i;
  assign on_st    = (conn_q == spc_pkg::CONN_ON);
  assign mcast_st = (conn_q == spc_pkg::CONN_MCAST);

  // Routing is combinational by design: the switch adds no retiming to the scan path.
  assign secondary_test_clock_o   = primary_test_clock_i;
  assign secondary_test_reset_n_o = primary_test_reset_n_i;

  assign secondary_serial_out_o    = primary_serial_in_i;
  assign primary_serial_out_o      = secondary_serial_in_i;
  assign secondary_serial_out_oe_o = byp_act | (~trst_act & (on_st | mcast_st));
  assign primary_serial_out_oe_o   = byp_act | (~trst_act & on_st);

  always_comb begin
    if (trst_act) begin
      secondary_mode_select_o = 1'b1;
    end else if (byp_act || on_st || mcast_st) begin
      secondary_mode_select_o = primary_mode_select_i;
    end else if (conn_q == spc_pkg::CONN_RESET) begin
      secondary_mode_select_o = 1'b1;
    end else begin
      secondary_mode_select_o = hold_q;
    end
  end

  // Last driven mode-select level, replayed while OFF or acknowledging; the RESET state forces it high instead.
  always_ff @(posedge primary_test_clock_i or negedge lrst2_q) begin
    if (!lrst2_q) begin
      hold_q <= 1'b1;
    end else begin
      hold_q <= secondary_mode_select_o;
    end
  end

  // The acknowledge state counts as not connected, so the indicator stays high there.
  assign connect_indicator_n_o = byp_act ? 1'b0 :
                                 (trst_act | ~(on_st | mcast_st));

  assign rx_hold_o        = byp_act | trst_act;
  assign rx_enable_o      = accept_state & ~rx_hold_o;
  assign rx_sync_enable_o = prim_paused & ~rx_hold_o;

  // ---------------- Status into the system domain ----------------

  logic conn_lvl_q;
  logic ack_lvl_q;
  logic conn1_q;
  logic ack1_q;

  always_ff @(posedge primary_test_clock_i or negedge lrst2_q) begin
    if (!lrst2_q) begin
      conn_lvl_q <= 1'b0;
      ack_lvl_q  <= 1'b0;
    end else begin
      conn_lvl_q <= on_st | mcast_st;
      ack_lvl_q  <= (conn_q == spc_pkg::CONN_ACK);
    end
  end

  // Both are slow levels, so two flops each are enough to cross.
  always_ff @(posedge mclk_i or negedge rst_sync2_q) begin
    if (!rst_sync2_q) begin
      conn1_q     <= 1'b0;
      ack1_q      <= 1'b0;
      connected_o <= 1'b0;
      ack_busy_o  <= 1'b0;
    end else begin
      conn1_q     <= conn_lvl_q;
      ack1_q      <= ack_lvl_q;
      connected_o <= conn1_q;
      ack_busy_o  <= ack1_q;
    end
  end

endmodule // spc_connect_ctrl

`default_nettype wire

// ===== tb/spc_connect_ctrl_monitor.sv
// Port checker for the scan port connect control block.
`default_nettype none
module spc_connect_ctrl_monitor #(
  parameter int unsigned ADDR_W = spc_pkg::ADDR_W
) (
  input wire logic              mclk_i,
  input wire logic              rst_b_i,
  input wire logic              primary_test_clock_i,
  input wire logic              primary_test_reset_n_i,
  input wire logic              primary_serial_out_oe_o,
  input wire logic              secondary_test_reset_n_o,
  input wire logic              secondary_mode_select_o,
  input wire logic              secondary_serial_out_oe_o,
  input wire logic [ADDR_W-1:0] strap_address_i,
  input wire logic              protocol_bypass_n_i,
  input wire logic              connect_indicator_n_o,
  input wire logic [ADDR_W-1:0] rx_addr_i,
  input wire logic              rx_addr_valid_i,
  input wire logic              rx_addr_short_i,
  input wire logic              ack_done_i,
  input wire logic              ack_start_o,
  input wire logic              rx_enable_o,
  input wire logic              rx_hold_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge primary_test_clock_i);
  endclocking
  default disable iff (!rst_b_i || !primary_test_reset_n_i);
  // Bypass high for three edges, since its synchroniser lags two.
  sequence s_take;
    protocol_bypass_n_i [*3] ##0 (rx_addr_valid_i && rx_enable_o);
  endsequence
  sequence s_ack_end;
    ack_start_o ##[1:8] (ack_done_i && protocol_bypass_n_i && !rx_addr_valid_i);
  endsequence
  a_match_ack: assert property (
    s_take ##0 (!rx_addr_short_i && rx_addr_i == strap_address_i && |rx_addr_i
      && !(&rx_addr_i[ADDR_W-1:1])) |=> ack_start_o && connect_indicator_n_o)
    else $error("strap match gave no acknowledge");
  a_ack_on: assert property (
    s_ack_end |-> ##[1:2] (!connect_indicator_n_o && secondary_serial_out_oe_o
      && primary_serial_out_oe_o))
    else $error("no connection after acknowledge");
  a_ack_con: assert property (
    ack_start_o && protocol_bypass_n_i |-> connect_indicator_n_o
      && !primary_serial_out_oe_o && !secondary_serial_out_oe_o)
    else $error("indicator active during acknowledge");
  a_disc_off: assert property (
    s_take ##0 rx_addr_i == spc_pkg::GLOBAL_DISC_CODE |=> connect_indicator_n_o
      && !primary_serial_out_oe_o && !secondary_serial_out_oe_o && !ack_start_o)
    else $error("disconnect code did not switch off");
  a_reset_code: assert property (
    s_take ##0 (!rx_addr_short_i && rx_addr_i == spc_pkg::RESET_CODE)
      |=> secondary_mode_select_o && !secondary_serial_out_oe_o && !ack_start_o)
    else $error("reset code did not force mode select high");
  a_short_off: assert property (
    s_take ##0 rx_addr_short_i |=> connect_indicator_n_o && !secondary_serial_out_oe_o)
    else $error("short address did not switch off");
  a_bypass_route: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i) !protocol_bypass_n_i |-> rx_hold_o
      && !connect_indicator_n_o && primary_serial_out_oe_o && secondary_serial_out_oe_o)
    else $error("bypass routing wrong");
  a_trst_status: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i) !primary_test_reset_n_i
      |-> !secondary_test_reset_n_o && secondary_mode_select_o
      && connect_indicator_n_o == protocol_bypass_n_i)
    else $error("test reset status wrong");
endmodule // spc_connect_ctrl_monitor

bind spc_connect_ctrl spc_connect_ctrl_monitor #(.ADDR_W(ADDR_W)) u_mon (.mclk_i, .rst_b_i,
  .primary_test_clock_i, .primary_test_reset_n_i, .primary_serial_out_oe_o,
  .secondary_test_reset_n_o, .secondary_mode_select_o, .secondary_serial_out_oe_o,
  .strap_address_i, .protocol_bypass_n_i, .connect_indicator_n_o, .rx_addr_i,
  .rx_addr_valid_i, .rx_addr_short_i, .ack_done_i, .ack_start_o, .rx_enable_o, .rx_hold_o);
`default_nettype wire

// ===== tb/spc_host_model.sv
// Test controller and acknowledge sender on the primary test port.
`default_nettype none
module spc_host_model (
  input  wire logic ack_start_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      ack_done_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int ack_wait = 1;
  int cnt = 0;
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    ack_done_o = 1'b0;
  end
  // The clock runs only while a cycle is asked for and stands still between frames.
  task automatic tick(input logic m);
    tms_o = m;
    #15 tck_o = 1'b1;
    #15 tck_o = 1'b0;
  endtask
  // A wait of one answers promptly; larger waits stretch the acknowledge.
  always @(negedge tck_o) begin
    ack_done_o <= (cnt == 1);
    if (ack_start_i) begin
      cnt <= ack_wait;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule // spc_host_model
`default_nettype wire

// ===== tb/spc_connect_ctrl_tb.sv
// Self-checking testbench for the scan port connect control block.
`default_nettype none
module spc_connect_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [9:0] STRAP = 10'h2A5;
  logic       mclk, rst_b, trst_n, psi, ssi, byp_n, valid, short_a, tck, tms, done, start;
  logic       pso, pso_oe, secondary_test_reset_n, secondary_mode_select, sso, sso_oe, con_n, rxe, rxs, hold, conn;
  logic [9:0] addr;
  logic       ack_b, secondary_test_clock;
  int         fail_count = 0;
  int         checks_done = 0;

  spc_host_model u_spc_host_model (.ack_start_i(start), .tck_o(tck), .tms_o(tms),
    .ack_done_o(done));
  spc_connect_ctrl u_spc_connect_ctrl (.mclk_i(mclk), .rst_b_i(rst_b),
    .primary_test_clock_i(tck), .primary_test_reset_n_i(trst_n),
    .primary_mode_select_i(tms), .primary_serial_in_i(psi), .primary_serial_out_o(pso),
    .primary_serial_out_oe_o(pso_oe), .secondary_test_clock_o(secondary_test_clock),
    .secondary_test_reset_n_o(secondary_test_reset_n), .secondary_mode_select_o(secondary_mode_select),
    .secondary_serial_out_o(sso), .secondary_serial_out_oe_o(sso_oe),
    .secondary_serial_in_i(ssi), .strap_address_i(STRAP), .protocol_bypass_n_i(byp_n),
    .connect_indicator_n_o(con_n), .rx_addr_i(addr), .rx_addr_valid_i(valid),
    .rx_addr_short_i(short_a), .ack_done_i(done), .ack_start_o(start), .rx_enable_o(rxe),
    .rx_sync_enable_o(rxs), .rx_hold_o(hold), .connected_o(conn), .ack_busy_o(ack_b));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [3:0] pins();
    return {con_n, pso_oe, sso_oe, secondary_mode_select};
  endfunction

  task automatic path(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) u_spc_host_model.tick(b[i]);
  endtask

  task automatic send(input logic [9:0] a, input logic s);
    addr = a;
    short_a = s;
    valid = 1'b1;
    u_spc_host_model.tick(tms);
    valid = 1'b0;
    addr = ~a;
  endtask

  task automatic connect(input int w);
    u_spc_host_model.ack_wait = w;
    send(STRAP, 1'b0);
    chk({con_n, pso_oe, sso_oe, start}, 4'b1001);
    path(8'h00, 1);
    repeat (4) @(posedge mclk);
    #1;
    chk({ack_b, conn, con_n, start}, 4'b1010);
    path(8'h00, w + 2);
    chk(pins(), {3'b011, tms});
  endtask

  task automatic t_match();
    path(8'h00, 1);
    connect(4);
    psi = 1'b0;
    ssi = 1'b1;
    #1;
    chk({pso, sso, 2'b00}, {ssi, psi, 2'b00});
    fork
      u_spc_host_model.tick(1'b0);
      begin
        #16;
        chk({secondary_test_clock, tck, 2'b00}, 4'b1100);
      end
    join
    repeat (6) @(posedge mclk);
    chk({conn, ack_b, 2'b00}, 4'b1000);
    $display("match test done");
  endtask

  task automatic t_codes();
    logic [9:0] code [4] = '{10'h3FE, 10'h000, 10'h155, STRAP};
    logic [3:0] exp [4] = '{4'h8, 4'h9, 4'h8, 4'h8};
    for (int i = 0; i < 4; i++) begin
      connect(1);
      send(code[i], i == 3);
      chk(pins(), exp[i]);
      path(8'h07, 3);
      chk(pins(), exp[i]);
      path(8'h00, 1);
    end
    $display("code test done");
  endtask

  task automatic t_sync();
    send(10'h3FF, 1'b0);
    chk(pins(), 4'h8);
    path(8'h00, 1);
    connect(1);
    path(8'h0B, 5);
    chk({rxs, rxe, 2'b00}, 4'b1100);
    send(10'h3FF, 1'b0);
    chk(pins(), 4'b0010);
    path(8'h03, 2);
    chk({rxe, pso_oe, sso_oe, secondary_mode_select}, 4'b0011);
    send(STRAP, 1'b0);
    chk({start, pso_oe, sso_oe, con_n}, 4'b0010);
    path(8'h03, 3);
    $display("sync test done");
  endtask

  task automatic t_bypass();
    byp_n = 1'b0;
    #1;
    chk(pins(), {3'b011, tms});
    chk({hold, 3'b000}, 4'b1000);
    path(8'h00, 3);
    send(10'h000, 1'b0);
    byp_n = 1'b1;
    #1;
    chk(pins(), 4'b0010);
    path(8'h00, 3);
    connect(1);
    $display("bypass test done");
  endtask

  task automatic t_trst();
    trst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(pins(), 4'b1001);
    chk({secondary_test_reset_n, hold, 2'b00}, 4'b0100);
    byp_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(pins(), 4'b0111);
    byp_n = 1'b1;
    trst_n = 1'b1;
    path(8'h07, 3);
    chk({rxe, rxs, 2'b00}, 4'b1000);
    connect(1);
    send(10'h000, 1'b0);
    chk(pins(), 4'b1001);
    $display("test reset test done");
  endtask

  initial begin
    rst_b = 1'b0;
    trst_n = 1'b0;
    byp_n = 1'b1;
    valid = 1'b0;
    short_a = 1'b0;
    addr = 10'h000;
    psi = 1'b1;
    ssi = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    trst_n = 1'b1;
    path(8'h07, 3);
    t_match();
    t_codes();
    t_sync();
    t_bypass();
    t_trst();
    test_done();
  end

  initial begin
    #50us;
    fail_count++;
    test_done();
  end
endmodule // spc_connect_ctrl_tb
`default_nettype wire
